// ==== pkg/rscl_cfg_if.sv ====
// latched configuration handed from the latch block to the grant-stop logic
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface rscl_cfg_if;
  logic long_grant_en;
  logic [4:0] min_grant_clocks;
  modport src (output long_grant_en, output min_grant_clocks);
  modport dst (input long_grant_en, input min_grant_clocks);
endinterface

// ==== pkg/rscl_pkg.sv ====
// strap configuration latch: shared constants, register map, types
// assumes a single 100 MHz clock domain and an AXI4-Lite register slave
// Behaviour
// RULE1: capture every strap pin level at reset release into both latch registers; the code latches pins 16, 18, 19, 21, 22, 23 and 25 only
// RULE2: strap without pull-up reads 0, strap with pull-up reads 1
// RULE3: software falling edge on secondary bit 3 re-samples all straps into both latches; the code re-samples the same seven pins as RULE1
// RULE4: high strap pin 25 sets secondary bit 7 and enables feature port pins
// RULE5: feature strap low gives pins alternate function; feature inputs ignored, outputs undriven
// RULE6: high strap pin 16 sets primary bit 0, selecting 32-bit PCI host bus
// RULE7: high strap pin 18 sets primary bit 2, selecting local bus above 33 MHz
// RULE8: high strap pin 19 sets primary bit 3, using external clocks, synthesizers off
// RULE9: high strap pin 21 sets primary bit 5, sleep address 46E8h, else 3C3h
// RULE10: high strap pin 22 sets primary bit 6, enabling dynamic frame-buffer sharing
// RULE11: high strap pin 23 sets primary bit 7, PCI bus, min-grant 8 to 16
// RULE12: board pulls up at most one of primary bits 7, 2, 0
// RULE13: no host-bus strap pulled up selects local bus at or below 33 MHz
// RULE14: extended min-grant asserts stop on period end, burst, or missing target ready
// RULE15: latched bits hold until next reset release or software re-sample
package rscl_pkg;

  // ***************************************************
  // strap pins and field positions
  // ***************************************************
  localparam int STRAP_W = 10;           // strap pins 16..25, index 0 is pin 16
  localparam int PIN_PCI = 0;
  localparam int PIN_FAST_LOCAL = 2;
  localparam int PIN_EXT_CLOCK = 3;
  localparam int PIN_ALT_SLEEP = 5;
  localparam int PIN_FB_SHARE = 6;
  localparam int PIN_LONG_GRANT = 7;
  localparam int PIN_FEATURE = 9;
  localparam int PRI_PCI_BIT = 0;
  localparam int PRI_FAST_LOCAL_BIT = 2;
  localparam int PRI_EXT_CLOCK_BIT = 3;
  localparam int PRI_ALT_SLEEP_BIT = 5;
  localparam int PRI_FB_SHARE_BIT = 6;
  localparam int PRI_LONG_GRANT_BIT = 7;
  localparam int SEC_RESAMPLE_BIT = 3;
  localparam int SEC_FEATURE_BIT = 7;
  localparam logic [7:0] PRIMARY_RESET = 8'h00;
  localparam logic [7:0] SECONDARY_RESET = 8'h00;

  // ***************************************************
  // register map and bus answers
  // ***************************************************
  localparam logic [7:0] REG_PRIMARY = 8'h00;
  localparam logic [7:0] REG_SECONDARY = 8'h04;
  localparam logic [7:0] REG_LIVE_STRAPS = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***************************************************
  // decoded values and timing counts
  // ***************************************************
  localparam logic [15:0] SLEEP_ADDR_ALT = 16'h46e8;
  localparam logic [15:0] SLEEP_ADDR_DEFAULT = 16'h03c3;
  localparam logic [4:0] MIN_GRANT_SHORT = 5'h08;   // pci clocks
  localparam logic [4:0] MIN_GRANT_LONG = 5'h10;    // pci clocks
  localparam logic [2:0] SYNC_FILL_CYCLES = 3'h5;   // filtered straps settle only after four edges

  typedef enum logic [1:0] {RSCL_SEL_PRIMARY, RSCL_SEL_SECONDARY, RSCL_SEL_LIVE, RSCL_SEL_NONE} rscl_sel_t;
  typedef enum {RSCL_CAP_FILL, RSCL_CAP_HOLD} rscl_cap_t;

endpackage

// ==== src/rscl_grant_stop.sv ====
// min-grant timer and stop request for the extended grant configuration
// assumes bus qualifiers arrive on aclk, already synchronous
`timescale 1ns/1ps
module rscl_grant_stop (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  rscl_cfg_if.dst cfg,
  input wire logic txn_active,
  input wire logic burst_active,
  input wire logic trdy_n,
  output logic stop_n
);
  logic [4:0] grant_cnt;
  logic trdy_seen;
  logic period_end;

  assign period_end = (grant_cnt >= cfg.min_grant_clocks - 5'h01);

  // count clocks of the current transaction, remember target ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grant_cnt <= '0;
      trdy_seen <= 1'b0;
    end else if (aclken) begin
      if (!txn_active) begin
        grant_cnt <= '0;
        trdy_seen <= 1'b0;
      end else begin
        if (!period_end) begin
          grant_cnt <= grant_cnt + 5'h01;
        end
        if (!trdy_n) begin
          trdy_seen <= 1'b1;
        end
      end
    end
  end

  // stop only in the extended mode; late target ready lets the host retry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_n <= 1'b1;
    end else if (aclken) begin
      stop_n <= !(cfg.long_grant_en && txn_active &&
                  (period_end || burst_active || (period_end && !trdy_seen))); // RULE14
    end
  end
endmodule

// ==== src/rscl_pin_sync.sv ====
// three-stage pin synchroniser with agreement filter
// assumes the pins are asynchronous to aclk
`timescale 1ns/1ps
module rscl_pin_sync #(
  parameter int W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // stage1 feeds only stage2, so metastability never reaches the filter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else if (aclken) begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level <= '0;
    end else if (aclken) begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i]; // RULE2
        end
      end
    end
  end
endmodule

// ==== src/rscl_top.sv ====
// strap configuration latch with AXI4-Lite register access
// assumes strap and shared pins are asynchronous, bus qualifiers are on aclk
`timescale 1ns/1ps
module rscl_top
  import rscl_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int FC_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  // register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // board straps
  input wire logic [STRAP_W-1:0] strap_memory_data_pins,
  // decoded configuration
  output logic pci_bus_select,
  output logic fast_local_bus_select,
  output logic slow_local_bus_select,
  output logic external_clock_select,
  output logic synth_power_down,
  output logic [15:0] sleep_io_address,
  output logic frame_buffer_share_en,
  output logic pci_long_grant_en,
  output logic [4:0] min_grant_clocks,
  output logic feature_port_en,
  // shared feature-port pins
  input wire logic [FC_W-1:0] shared_pin_in,
  output logic [FC_W-1:0] shared_pin_out,
  output logic [FC_W-1:0] shared_pin_oe,
  input wire logic [FC_W-1:0] feature_out_data,
  input wire logic [FC_W-1:0] feature_out_en,
  output logic [FC_W-1:0] feature_in_data,
  input wire logic [FC_W-1:0] alt_out_data,
  input wire logic [FC_W-1:0] alt_out_en,
  output logic [FC_W-1:0] alt_in_data,
  // pci transaction qualifiers and stop request
  input wire logic pci_txn_active,
  input wire logic pci_burst_active,
  input wire logic pci_trdy_n,
  output logic pci_stop_n
);

  // ***************************************************
  // address decode
  // ***************************************************

  // shared by the read and write paths; misaligned or unknown words fail
  function automatic rscl_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    rscl_sel_t sel;
    sel = RSCL_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      if (ADDR_W'(REG_PRIMARY) == addr) begin
        sel = RSCL_SEL_PRIMARY;
      end else if (ADDR_W'(REG_SECONDARY) == addr) begin
        sel = RSCL_SEL_SECONDARY;
      end else if (ADDR_W'(REG_LIVE_STRAPS) == addr) begin
        sel = RSCL_SEL_LIVE;
      end
    end
    return sel;
  endfunction

  // ***************************************************
  // declarations
  // ***************************************************
  logic [STRAP_W-1:0] strap_level;
  logic [FC_W-1:0] shared_level;
  rscl_cap_t cap_state;
  logic [2:0] fill_cnt;
  logic capture_now;
  logic resample_req;
  logic [7:0] strap_config_latch_primary;
  logic feature_latch;
  logic resample_ctl;
  logic aw_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_held;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_commit;
  rscl_sel_t wr_sel;
  rscl_sel_t rd_sel;
  logic [7:0] strap_config_latch_secondary;
  logic [7:0] next_primary;
  rscl_cfg_if cfg_link ();

  // ***************************************************
  // pin synchronisers
  // ***************************************************

  // straps are sampled through the filter so a bouncing pull-up cannot split bits
  rscl_pin_sync #(
    .W(STRAP_W)
  ) u_strap_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclken(aclken),
    .pin(strap_memory_data_pins),
    .level(strap_level)
  );

  // shared pins come from the external video source, also asynchronous
  rscl_pin_sync #(
    .W(FC_W)
  ) u_shared_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclken(aclken),
    .pin(shared_pin_in),
    .level(shared_level)
  );

  // ***************************************************
  // capture sequencing
  // ***************************************************

  // reset clears the stages, so capture waits until the filter shows the pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_state <= RSCL_CAP_FILL;
      fill_cnt <= 3'h0;
    end else if (aclken) begin
      unique case (cap_state)
        RSCL_CAP_FILL: begin
          if (fill_cnt == SYNC_FILL_CYCLES - 3'h1) begin
            cap_state <= RSCL_CAP_HOLD;
          end else begin
            fill_cnt <= fill_cnt + 3'h1;
          end
        end
        RSCL_CAP_HOLD: begin
          fill_cnt <= fill_cnt;
        end
      endcase
    end
  end

  // one capture at reset release, one per software falling edge
  assign capture_now = ((cap_state == RSCL_CAP_FILL) && (fill_cnt == SYNC_FILL_CYCLES - 3'h1)) // RULE1
                       || resample_req; // RULE3

  // map strap pins onto primary latch bits; reserved pins stay zero
  always_comb begin
    next_primary = PRIMARY_RESET;
    next_primary[PRI_PCI_BIT] = strap_level[PIN_PCI]; // RULE6
    next_primary[PRI_FAST_LOCAL_BIT] = strap_level[PIN_FAST_LOCAL]; // RULE7
    next_primary[PRI_EXT_CLOCK_BIT] = strap_level[PIN_EXT_CLOCK]; // RULE8
    next_primary[PRI_ALT_SLEEP_BIT] = strap_level[PIN_ALT_SLEEP]; // RULE9
    next_primary[PRI_FB_SHARE_BIT] = strap_level[PIN_FB_SHARE]; // RULE10
    next_primary[PRI_LONG_GRANT_BIT] = strap_level[PIN_LONG_GRANT]; // RULE11
  end

  // ***************************************************
  // configuration latches
  // ***************************************************

  // latches move only on a capture, never with live pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_config_latch_primary <= PRIMARY_RESET;
      feature_latch <= 1'b0;
    end else if (aclken && capture_now) begin
      strap_config_latch_primary <= next_primary; // RULE15
      feature_latch <= strap_level[PIN_FEATURE]; // RULE4
    end
  end

  // secondary view: feature latch plus the software re-sample control
  always_comb begin
    strap_config_latch_secondary = SECONDARY_RESET;
    strap_config_latch_secondary[SEC_FEATURE_BIT] = feature_latch;
    strap_config_latch_secondary[SEC_RESAMPLE_BIT] = resample_ctl;
  end

  // ***************************************************
  // register bus: write path
  // ***************************************************

  // address and data in either order; the answer waits for both
  assign s_axi_awready = aclken && !aw_held && !s_axi_bvalid;
  assign s_axi_wready = aclken && !w_held && !s_axi_bvalid;
  assign wr_commit = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel = decode_addr(aw_addr_q);

  // hold address and data until commit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
      w_held <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (aclken) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_commit) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_commit) begin
        w_held <= 1'b0;
      end
    end
  end

  // answer stands until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (aclken) begin
      if (wr_commit) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == RSCL_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // only the re-sample bit is writable; 1-to-0 triggers a capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resample_ctl <= 1'b0;
      resample_req <= 1'b0;
    end else if (aclken) begin
      resample_req <= 1'b0;
      if (wr_commit && (wr_sel == RSCL_SEL_SECONDARY) && w_strb_q[0]) begin
        resample_ctl <= w_data_q[SEC_RESAMPLE_BIT];
        resample_req <= resample_ctl && !w_data_q[SEC_RESAMPLE_BIT]; // RULE3
      end
    end
  end

  // ***************************************************
  // register bus: read path
  // ***************************************************
  assign s_axi_arready = aclken && !s_axi_rvalid;
  assign rd_sel = decode_addr(s_axi_araddr);

  // read data is registered; live straps are the filtered pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (aclken) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (rd_sel)
          RSCL_SEL_PRIMARY: s_axi_rdata <= {24'h0, strap_config_latch_primary};
          RSCL_SEL_SECONDARY: s_axi_rdata <= {24'h0, strap_config_latch_secondary};
          RSCL_SEL_LIVE: s_axi_rdata <= {22'h0, strap_level};
          RSCL_SEL_NONE: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ***************************************************
  // decoded configuration outputs
  // ***************************************************

  // bus straps assumed exclusive on the board; no arbitration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pci_bus_select <= 1'b0;
      fast_local_bus_select <= 1'b0;
      slow_local_bus_select <= 1'b1;
      pci_long_grant_en <= 1'b0;
      min_grant_clocks <= MIN_GRANT_SHORT;
    end else if (aclken) begin
      pci_bus_select <= strap_config_latch_primary[PRI_PCI_BIT]
                        || strap_config_latch_primary[PRI_LONG_GRANT_BIT]; // RULE12
      fast_local_bus_select <= strap_config_latch_primary[PRI_FAST_LOCAL_BIT];
      slow_local_bus_select <= !(strap_config_latch_primary[PRI_PCI_BIT]
                                 || strap_config_latch_primary[PRI_FAST_LOCAL_BIT]
                                 || strap_config_latch_primary[PRI_LONG_GRANT_BIT]); // RULE13
      pci_long_grant_en <= strap_config_latch_primary[PRI_LONG_GRANT_BIT];
      min_grant_clocks <= strap_config_latch_primary[PRI_LONG_GRANT_BIT]
                          ? MIN_GRANT_LONG : MIN_GRANT_SHORT; // RULE11
    end
  end

  // clock source, sleep address and frame sharing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      external_clock_select <= 1'b0;
      synth_power_down <= 1'b0;
      sleep_io_address <= SLEEP_ADDR_DEFAULT;
      frame_buffer_share_en <= 1'b0;
    end else if (aclken) begin
      external_clock_select <= strap_config_latch_primary[PRI_EXT_CLOCK_BIT]; // RULE8
      synth_power_down <= strap_config_latch_primary[PRI_EXT_CLOCK_BIT];
      sleep_io_address <= strap_config_latch_primary[PRI_ALT_SLEEP_BIT]
                          ? SLEEP_ADDR_ALT : SLEEP_ADDR_DEFAULT; // RULE9
      frame_buffer_share_en <= strap_config_latch_primary[PRI_FB_SHARE_BIT]; // RULE10
    end
  end

  // ***************************************************
  // shared pin multiplexing
  // ***************************************************

  // disabled port sees zeros, never drives; outputs lag one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feature_port_en <= 1'b0;
      shared_pin_out <= '0;
      shared_pin_oe <= '0;
      feature_in_data <= '0;
      alt_in_data <= '0;
    end else if (aclken) begin
      feature_port_en <= feature_latch; // RULE4
      if (feature_latch) begin
        shared_pin_out <= feature_out_data; // RULE4
        shared_pin_oe <= feature_out_en;
        feature_in_data <= shared_level;
        alt_in_data <= '0;
      end else begin
        shared_pin_out <= alt_out_data; // RULE5
        shared_pin_oe <= alt_out_en;
        feature_in_data <= '0;
        alt_in_data <= shared_level;
      end
    end
  end

  // ***************************************************
  // extended min-grant stop logic
  // ***************************************************
  assign cfg_link.long_grant_en = pci_long_grant_en;
  assign cfg_link.min_grant_clocks = min_grant_clocks;

  rscl_grant_stop u_grant_stop (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclken(aclken),
    .cfg(cfg_link.dst),
    .txn_active(pci_txn_active),
    .burst_active(pci_burst_active),
    .trdy_n(pci_trdy_n),
    .stop_n(pci_stop_n)
  );

endmodule

// ==== tb/rscl_strap_board.sv ====
// board strap resistors in front of the memory data pins
// assumes the bench chooses which straps carry a pull-up
`timescale 1ns/1ps
module rscl_strap_board
  import rscl_pkg::*;
(
  input wire logic [STRAP_W-1:0] pullup_fit,
  output logic [STRAP_W-1:0] pins
);
  // bare pins fall to the internal pull-down; only one bus strap may be fitted
  always_comb begin
    pins = pullup_fit;
    if (pins[PIN_LONG_GRANT]) begin
      pins[PIN_PCI] = 1'b0;
      pins[PIN_FAST_LOCAL] = 1'b0;
    end else if (pins[PIN_FAST_LOCAL]) begin
      pins[PIN_PCI] = 1'b0;
    end
  end
endmodule

// ==== tb/rscl_top_asserts.sv ====
// checker: decoded straps, shared pins, stop request
// assumes it is bound to rscl_top, one aclk domain, aclken held high by the bench
`timescale 1ns/1ps
module rscl_top_chk
  import rscl_pkg::*;
#(
  parameter int FC_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  input wire logic pci_bus_select,
  input wire logic fast_local_bus_select,
  input wire logic slow_local_bus_select,
  input wire logic external_clock_select,
  input wire logic synth_power_down,
  input wire logic [15:0] sleep_io_address,
  input wire logic pci_long_grant_en,
  input wire logic [4:0] min_grant_clocks,
  input wire logic feature_port_en,
  input wire logic [FC_W-1:0] feature_in_data,
  input wire logic [FC_W-1:0] alt_in_data,
  input wire logic pci_txn_active,
  input wire logic pci_burst_active,
  input wire logic pci_stop_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ********
  // decode relations
  // ********
  // decode is registered as one group, so these tie outputs together each edge
  chk_sleep_value: assert property (
    sleep_io_address == SLEEP_ADDR_ALT || sleep_io_address == SLEEP_ADDR_DEFAULT)
    else $error("bad sleep address");
  chk_grant_len: assert property (
    min_grant_clocks == (pci_long_grant_en ? MIN_GRANT_LONG : MIN_GRANT_SHORT))
    else $error("bad min grant length");
  chk_long_is_pci: assert property (
    pci_long_grant_en |-> pci_bus_select && !fast_local_bus_select)
    else $error("long grant without pci");
  chk_slow_default: assert property (
    slow_local_bus_select == !(pci_bus_select || fast_local_bus_select))
    else $error("slow local bus select wrong");
  chk_ext_clock: assert property (
    synth_power_down == external_clock_select)
    else $error("synth power down not external clock");
  // ********
  // shared pins and stop
  // ********
  chk_feat_off_in: assert property (
    !feature_port_en && !$past(feature_port_en) |-> feature_in_data == '0)
    else $error("feature inputs while disabled");
  chk_feat_on_alt: assert property (
    feature_port_en && $past(feature_port_en) |-> alt_in_data == '0)
    else $error("alternate inputs while feature on");
  chk_burst_stop: assert property (
    aclken && pci_long_grant_en && pci_txn_active && pci_burst_active |=> !pci_stop_n)
    else $error("no stop during burst");
  chk_stop_idle: assert property (
    !pci_txn_active && !$past(pci_txn_active) |-> pci_stop_n)
    else $error("stop with no transaction");
  cov_long_stop: cover property (pci_long_grant_en && !pci_stop_n);
  cov_feature: cover property (feature_port_en);
  cov_pci: cover property (pci_bus_select && !pci_long_grant_en);
endmodule
bind rscl_top rscl_top_chk #(.FC_W(FC_W)) u_rscl_top_chk (.*);

// ==== tb/rscl_top_tb_top.sv ====
// bench: capture, hold, re-sample, bus, shared pins, stop
// assumes rscl_top with default widths, aclk at 100 MHz
`timescale 1ns/1ps
module rscl_top_tb_top
  import rscl_pkg::*;
;
  logic aclk, aresetn, aclken, awv, wv, bre, arv, rre, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, spi, spo, spoe, fod, foe, fid, aod, aoe, aid;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [9:0] fit, pins;
  logic pci, fast, slow, extc, synth, fbs, lgr, feat, txn, burst, stop_n;
  logic [15:0] sleep, seed;
  logic [4:0] mg;
  int n_errors, comparisons;
  always #5 aclk = ~aclk;
  rscl_strap_board u_rscl_strap_board (.pullup_fit(fit), .pins(pins));
  rscl_top u_rscl_top (
    .aclk(aclk), .aresetn(aresetn), .aclken(aclken), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bre), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rre), .strap_memory_data_pins(pins), .pci_bus_select(pci),
    .fast_local_bus_select(fast), .slow_local_bus_select(slow), .external_clock_select(extc),
    .synth_power_down(synth), .sleep_io_address(sleep), .frame_buffer_share_en(fbs),
    .pci_long_grant_en(lgr), .min_grant_clocks(mg), .feature_port_en(feat), .shared_pin_in(spi),
    .shared_pin_out(spo), .shared_pin_oe(spoe), .feature_out_data(fod), .feature_out_en(foe),
    .feature_in_data(fid), .alt_out_data(aod), .alt_out_en(aoe), .alt_in_data(aid),
    .pci_txn_active(txn), .pci_burst_active(burst), .pci_trdy_n(1'b1), .pci_stop_n(stop_n));
  // ********
  // helpers
  // ********
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // decoded outputs, packed as the bench packs them
  function automatic logic [31:0] exp_dec(input logic [9:0] p);
    logic bus;
    bus = p[0] | p[7];
    return {3'h0, bus, p[2], !(bus | p[2]), p[3], p[3], p[6], p[7], p[9],
            p[5] ? 16'h46e8 : 16'h03c3, p[7] ? 5'h10 : 5'h08};
  endfunction
  // pin owner follows the feature strap; idle side sees zero
  function automatic logic [31:0] exp_pin(input logic f);
    return f ? {foe, fod, spi, 8'h00} : {aoe, aod, 8'h00, spi};
  endfunction
  task automatic give_verdict;
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang(input int k);
    if (k > 50) begin
      n_errors++;
      $display("Error %0t: bus answer never came", $time);
      give_verdict();
    end
  endtask
  // an edge passes first so no strobe is set twice in one step
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    for (k = 1; k <= 50; k++) begin
      @(posedge aclk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bre <= 1'b0;
        break;
      end
    end
    hang(k);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    for (k = 1; k <= 50; k++) begin
      @(posedge aclk);
      if (arready) arv <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rre <= 1'b0;
        break;
      end
    end
    hang(k);
  endtask
  // straps settle during reset; capture lands five edges after release
  task automatic do_reset(input logic [9:0] m);
    @(posedge aclk);
    fit <= m;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (5) @(posedge aclk);
  endtask
  // ********
  // main sequence
  // ********
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [9:0] old;
    int n;
    {aclk, aresetn, awv, wv, bre, arv, rre, txn, burst} = 9'h0;
    {awaddr, araddr, wdata, fit, spi, fod, foe, aod, aoe} = 'h0;
    aclken = 1'b1;
    seed = 16'h0057;
    n_errors = 0;
    comparisons = 0;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      do_reset(i == 0 ? 10'h000 : i == 1 ? 10'h3ff : seed[9:0]);
      {fod, foe} <= seed;
      seed = lfsr(seed);
      {aod, aoe} <= seed;
      spi <= seed[15:8] ^ seed[7:0];
      axr(REG_PRIMARY, d, r);
      chk(d, {24'h0, pins[7:0] & 8'hed});
      axr(REG_SECONDARY, d, r);
      chk(d, {24'h0, pins[9], 7'h00});
      chk({3'h0, pci, fast, slow, extc, synth, fbs, lgr, feat, sleep, mg}, exp_dec(pins));
      repeat (8) @(posedge aclk);
      chk({spoe, spo, fid, aid}, exp_pin(pins[9]));
    end
    // moved straps must not reach the latches until software asks
    old = pins;
    fit <= ~fit;
    repeat (10) @(posedge aclk);
    axr(REG_PRIMARY, d, r);
    chk(d, {24'h0, old[7:0] & 8'hed});
    axw(REG_SECONDARY, 32'h08, r);
    axr(REG_SECONDARY, d, r);
    chk(d, {24'h0, old[9], 7'h08});
    axw(REG_SECONDARY, 32'h00, r);
    repeat (5) @(posedge aclk);
    axr(REG_PRIMARY, d, r);
    chk(d, {24'h0, pins[7:0] & 8'hed});
    chk({3'h0, pci, fast, slow, extc, synth, fbs, lgr, feat, sleep, mg}, exp_dec(pins));
    axw(REG_PRIMARY, 32'hff, r);
    axr(REG_PRIMARY, d, r);
    chk(d, {24'h0, pins[7:0] & 8'hed});
    axr(8'h0c, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    // long grant: a held transaction is stopped near the sixteenth clock
    do_reset(10'h080);
    txn <= 1'b1;
    n = 0;
    while (stop_n === 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, n >= 14 && n <= 20}, 32'h1);
    txn <= 1'b0;
    repeat (3) @(posedge aclk);
    txn <= 1'b1;
    burst <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({31'h0, stop_n}, 32'h0);
    txn <= 1'b0;
    burst <= 1'b0;
    repeat (3) @(posedge aclk);
    give_verdict();
  end
endmodule
